// file: inc/ppt_defs.svh
// timing counts, field positions and register offsets for the pressure pulse train link
`ifndef PPT_DEFS_SVH
`define PPT_DEFS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PPT_CLK_MHZ        50
`define PPT_START_DLY_US   1000
`define PPT_START_MAX_MS   100
`define PPT_START_DLY_CYC  (`PPT_START_DLY_US * `PPT_CLK_MHZ)
`define PPT_SLOW_HZ        5000
`define PPT_FAST_HZ        50000
`define PPT_SLOW_HALF_CYC  ((`PPT_CLK_MHZ * 1000000) / (2 * `PPT_SLOW_HZ))
`define PPT_FAST_HALF_CYC  ((`PPT_CLK_MHZ * 1000000) / (2 * `PPT_FAST_HZ))
`define PPT_TRIG_MIN_NS    1000
`define PPT_TRIG_MIN_CYC   ((`PPT_TRIG_MIN_NS * `PPT_CLK_MHZ + 999) / 1000)
`define PPT_MS_CYC         (`PPT_CLK_MHZ * 1000)
`define PPT_LOW_RES_DIV    10

// ----------------------------------------
// host register map (byte addresses)
// ----------------------------------------
`define PPT_REG_CTRL       8'h00
`define PPT_REG_GATE       8'h04
`define PPT_REG_COUNT      8'h08
`define PPT_REG_STATUS     8'h0C
`define PPT_CTRL_START     0
`define PPT_CTRL_CLR_DONE  1
`define PPT_STAT_BUSY      0
`define PPT_STAT_DONE      1
`define PPT_STAT_GATE      2
`define PPT_GATE_MS_RST    16'h0BB8

`endif

// file: inc/ppt_pkg.sv
// types shared by both ends of the pressure pulse train link
package ppt_pkg;

	// selected pressure unit
	typedef enum logic [3:0] {
		PPT_UNIT_HPA  = 4'h0,
		PPT_UNIT_KPA  = 4'h1,
		PPT_UNIT_PA   = 4'h2,
		PPT_UNIT_MBAR = 4'h3,
		PPT_UNIT_INHG = 4'h4,
		PPT_UNIT_MMHG = 4'h5,
		PPT_UNIT_TORR = 4'h6,
		PPT_UNIT_MMH2O = 4'h7,
		PPT_UNIT_PSIA = 4'h8
	} ppt_unit_t;

	// device burst sequencer
	typedef enum logic [3:0] {
		PPT_DEV_IDLE  = 4'h1,
		PPT_DEV_DELAY = 4'h2,
		PPT_DEV_LOW   = 4'h4,
		PPT_DEV_HIGH  = 4'h8
	} ppt_dev_state_t;

	// host counter sequencer
	typedef enum logic [2:0] {
		PPT_HST_IDLE = 3'h1,
		PPT_HST_TRIG = 3'h2,
		PPT_HST_GATE = 3'h4
	} ppt_hst_state_t;

endpackage : ppt_pkg

// file: inc/ppt_if.sv
// trigger and pulse lines between the barometer and the host counter
`timescale 1ns/1ps
interface ppt_if;
	logic trig;   // host to device, rests high
	logic pulse;  // device to host, rests high

	modport dev  (input trig, output pulse);
	modport host (output trig, input pulse);
endinterface : ppt_if

// file: rtl/ppt_device.sv
// barometer end: trigger edge detection and pressure pulse burst generator
//
// Added by the designer: the address map and the Wishbone slave port, both at the host end, not in this module.
`timescale 1ns/1ps
`include "ppt_defs.svh"

module ppt_device #(
	parameter int unsigned PW         = 24,
	parameter int unsigned START_CYC  = `PPT_START_DLY_CYC,
	parameter int unsigned SLOW_HALF  = `PPT_SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF  = `PPT_FAST_HALF_CYC
) (
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	input  wire logic               ce_i,
	ppt_if.dev                      link,
	input  wire logic               pulse_enable_i,
	input  wire logic               trigger_wait_enable_switch_i,
	input  wire ppt_pkg::ppt_unit_t unit_i,
	input  wire logic               fast_rate_i,
	input  wire logic               high_res_i,
	input  wire logic               error_i,
	input  wire logic [PW-1:0]      pressure_i,
	input  wire logic [PW-1:0]      offset_i,
	output logic                    busy_o,
	output logic [PW-1:0]           burst_len_o
);
	import ppt_pkg::*;

	localparam int unsigned TW = 20;
	localparam logic [TW-1:0] START_LAST = TW'(START_CYC - 1);
	localparam logic [TW-1:0] SLOW_LAST  = TW'(SLOW_HALF - 1);
	localparam logic [TW-1:0] FAST_LAST  = TW'(FAST_HALF - 1);

	// ----------------------------------------
	// functions
	// ----------------------------------------

	// offset-corrected pressure in 0.01 units, divided down to the resolution
	function automatic logic [PW-1:0] burst_count(
		input logic [PW-1:0] press,
		input logic [PW-1:0] offs,
		input logic          hres
	);
		logic signed [PW:0] sum;
		logic [PW-1:0]      mag;
		sum = $signed({1'b0, press}) + $signed({offs[PW-1], offs});
		mag = sum[PW-1:0];
		if (sum <= 0) begin
			burst_count = '0;
		end else if (hres) begin
			burst_count = mag;
		end else begin
			burst_count = PW'(mag / PW'(`PPT_LOW_RES_DIV));
		end
	endfunction : burst_count

	// half period of one pulse at the selected rate
	function automatic logic [TW-1:0] half_last(input logic fast);
		half_last = fast ? FAST_LAST : SLOW_LAST;
	endfunction : half_last

	// ----------------------------------------
	// state
	// ----------------------------------------
	ppt_dev_state_t  state_r;
	ppt_dev_state_t  state_nxt;
	logic [TW-1:0]   tmr_r;
	logic [PW-1:0]   left_r;
	logic            fast_r;
	logic            trig_s1_r;
	logic            trig_s2_r;
	logic            trig_d_r;
	logic            pulse_r;
	logic            trig_fall;
	logic            armed;
	logic            tmr_done;
	logic [PW-1:0]   count_now;

	// ----------------------------------------
	// trigger input synchroniser
	// ----------------------------------------

	// the trigger pin is asynchronous to clk_i, so two flops before any use
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			trig_s1_r <= 1'b1;
			trig_s2_r <= 1'b1;
			trig_d_r  <= 1'b1;
		end else if (ce_i) begin
			trig_s1_r <= link.trig;
			trig_s2_r <= trig_s1_r;
			trig_d_r  <= trig_s2_r;
		end
	end

	// falling edge only
	// a rising edge never starts a burst, so the trigger must rest high and pulse low
	assign trig_fall = trig_d_r & ~trig_s2_r;

	// host pulse width relied on
	// pulses of at least 1 us span many clocks, so the sampled edge is never missed

	assign armed = pulse_enable_i & trigger_wait_enable_switch_i
		& ((unit_i == PPT_UNIT_HPA) | (unit_i == PPT_UNIT_MBAR));

	assign count_now = burst_count(pressure_i, offset_i, high_res_i);
	assign tmr_done  = (tmr_r == '0);

	// ----------------------------------------
	// burst sequencer
	// ----------------------------------------

	// next state of the burst sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PPT_DEV_IDLE: begin
				if (trig_fall && armed && !error_i && count_now != '0) begin
					state_nxt = PPT_DEV_DELAY;
				end
			end
			PPT_DEV_DELAY: begin
				if (error_i) begin
					state_nxt = PPT_DEV_IDLE;
				end else if (tmr_done) begin
					state_nxt = PPT_DEV_LOW;
				end
			end
			PPT_DEV_LOW: begin
				if (tmr_done) begin
					state_nxt = PPT_DEV_HIGH;
				end
			end
			PPT_DEV_HIGH: begin
				if (tmr_done) begin
					state_nxt = (left_r == PW'(1)) ? PPT_DEV_IDLE : PPT_DEV_LOW;
				end
			end
			default: begin
				state_nxt = PPT_DEV_IDLE;
			end
		endcase
	end

	// state register; trigger edges outside idle fall through unseen
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= PPT_DEV_IDLE;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// phase timer
	// ----------------------------------------

	// one down-counter serves the start delay and both pulse phases
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tmr_r <= '0;
		end else if (ce_i) begin
			if (state_r == PPT_DEV_IDLE) begin
				tmr_r <= START_LAST;
			end else if (tmr_done) begin
				tmr_r <= half_last(fast_r);
			end else begin
				tmr_r <= tmr_r - TW'(1);
			end
		end
	end

	// ----------------------------------------
	// burst length and rate capture
	// ----------------------------------------

	// settings are frozen at the trigger so a change mid-burst cannot skew the count
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			left_r      <= '0;
			fast_r      <= 1'b0;
			burst_len_o <= '0;
		end else if (ce_i) begin
			if (state_r == PPT_DEV_IDLE && state_nxt == PPT_DEV_DELAY) begin
				left_r      <= count_now;
				fast_r      <= fast_rate_i;
				burst_len_o <= count_now;
			end else if (state_r == PPT_DEV_HIGH && tmr_done) begin
				left_r <= left_r - PW'(1);
			end
		end
	end

	// ----------------------------------------
	// pulse output
	// ----------------------------------------

	// registered so the line carries no decode glitches
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pulse_r <= 1'b1;
		end else if (ce_i) begin
			pulse_r <= (state_nxt != PPT_DEV_LOW);
		end
	end

	assign link.pulse = pulse_r;
	assign busy_o     = (state_r != PPT_DEV_IDLE);

endmodule : ppt_device

// file: rtl/ppt_host.sv
// host end: gated pulse counter with trigger generator behind a wishbone slave
`timescale 1ns/1ps
`include "ppt_defs.svh"

module ppt_host #(
	parameter int unsigned CW      = 24,
	parameter int unsigned MS_CYC  = `PPT_MS_CYC,
	parameter int unsigned TRIG_CYC = `PPT_TRIG_MIN_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	ppt_if.host              link,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);
	import ppt_pkg::*;

	localparam logic [15:0] MS_LAST   = 16'(MS_CYC - 1);
	localparam logic [15:0] TRIG_LAST = 16'(TRIG_CYC - 1);

	ppt_hst_state_t state_r;
	logic [15:0]    gate_ms_r;
	logic [15:0]    ms_left_r;
	logic [15:0]    tmr_r;
	logic [CW-1:0]  count_r;
	logic           done_r;
	logic           trig_r;
	logic           p_s1_r;
	logic           p_s2_r;
	logic           p_d_r;
	logic           req;
	logic           wr;
	logic           start;
	logic           finish;

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------

	// one wait state: ack one cycle after the request, dropped the next
	// writes land at the ack edge, the same edge at which the master sees the answer
	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign start = wr && wb_adr_i == `PPT_REG_CTRL && wb_sel_i[0] && wb_dat_i[`PPT_CTRL_START]
		&& state_r == PPT_HST_IDLE;

	// ack and read data are both registered
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= req;
			wb_dat_o <= '0;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					`PPT_REG_GATE:   wb_dat_o <= {16'h0000, gate_ms_r};
					`PPT_REG_COUNT:  wb_dat_o <= 32'(count_r);
					`PPT_REG_STATUS: wb_dat_o <= {29'h0, state_r == PPT_HST_GATE, done_r,
						state_r != PPT_HST_IDLE};
					default:         wb_dat_o <= '0;
				endcase
			end
		end
	end

	// gate time in ms, byte lanes honoured
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gate_ms_r <= `PPT_GATE_MS_RST;
		end else if (ce_i && wr && wb_adr_i == `PPT_REG_GATE) begin
			if (wb_sel_i[0]) begin
				gate_ms_r[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				gate_ms_r[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// ----------------------------------------
	// pulse input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			p_s1_r <= 1'b1;
			p_s2_r <= 1'b1;
			p_d_r  <= 1'b1;
		end else if (ce_i) begin
			p_s1_r <= link.pulse;
			p_s2_r <= p_s1_r;
			p_d_r  <= p_s2_r;
		end
	end

	// ----------------------------------------
	// measurement sequencer
	// ----------------------------------------
	assign finish = (state_r == PPT_HST_GATE) && tmr_r == '0 && ms_left_r == '0;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r   <= PPT_HST_IDLE;
			tmr_r     <= '0;
			ms_left_r <= '0;
			trig_r    <= 1'b1;
		end else if (ce_i) begin
			case (state_r)
				PPT_HST_IDLE: begin
					if (start) begin
						state_r <= PPT_HST_TRIG;
						// trigger low at least 1 us
						tmr_r   <= TRIG_LAST;
						trig_r  <= 1'b0;
					end
				end
				PPT_HST_TRIG: begin
					if (tmr_r == '0) begin
						state_r   <= PPT_HST_GATE;
						trig_r    <= 1'b1;
						tmr_r     <= MS_LAST;
						ms_left_r <= gate_ms_r;
					end else begin
						tmr_r <= tmr_r - 16'h0001;
					end
				end
				PPT_HST_GATE: begin
					if (finish) begin
						state_r <= PPT_HST_IDLE;
					end else if (tmr_r == '0) begin
						tmr_r     <= MS_LAST;
						ms_left_r <= ms_left_r - 16'h0001;
					end else begin
						tmr_r <= tmr_r - 16'h0001;
					end
				end
				default: begin
					state_r <= PPT_HST_IDLE;
					trig_r  <= 1'b1;
				end
			endcase
		end
	end

	assign link.trig = trig_r;

	// ----------------------------------------
	// pulse counter and done flag
	// ----------------------------------------

	// count each falling edge outside idle
	// the sync chain resolves 50 kHz pulses easily at 50 MHz
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_r <= '0;
		end else if (ce_i) begin
			if (start) begin
				count_r <= '0;
			end else if (state_r != PPT_HST_IDLE && p_d_r && !p_s2_r) begin
				count_r <= count_r + CW'(1);
			end
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			done_r <= 1'b0;
		end else if (ce_i) begin
			if (finish) begin
				done_r <= 1'b1;
			end else if (start || (wr && wb_adr_i == `PPT_REG_CTRL && wb_sel_i[0]
				&& wb_dat_i[`PPT_CTRL_CLR_DONE])) begin
				done_r <= 1'b0;
			end
		end
	end

endmodule : ppt_host

// file: sim/ppt_assertions.sv
// concurrent checks on the trigger and pulse lines of the link
`timescale 1ns/1ps
`include "ppt_defs.svh"
module ppt_assertions #(
	parameter int unsigned PW        = 24,
	parameter int unsigned START_CYC = 20,
	parameter int unsigned SLOW_HALF = 10,
	parameter int unsigned FAST_HALF = 4,
	parameter int unsigned TRIG_CYC  = 50
) (
	input wire logic          clk_i,
	input wire logic          resetn_i,
	input wire logic          trig,
	input wire logic          pulse,
	input wire logic          busy_o,
	input wire logic          fast_rate_i,
	input wire logic [PW-1:0] burst_len_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ----------------------------------------
	// phase counters
	// ----------------------------------------
	logic [15:0] low_cnt, high_cnt, tlow_cnt, since_fall;
	logic        trig_q, pulsed_r;
	int unsigned half;
	assign half = fast_rate_i ? FAST_HALF : SLOW_HALF;

	// lengths of each line phase; since_fall saturates so reset gives no false edge
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_cnt <= 16'h0000;
			high_cnt <= 16'h0000;
			tlow_cnt <= 16'h0000;
			since_fall <= 16'hFFFF;
			trig_q <= 1'h1;
			pulsed_r <= 1'h0;
		end else begin
			low_cnt <= pulse ? 16'h0000 : low_cnt + 16'h0001;
			high_cnt <= pulse ? high_cnt + 16'h0001 : 16'h0000;
			tlow_cnt <= trig ? 16'h0000 : tlow_cnt + 16'h0001;
			trig_q <= trig;
			if (trig_q && !trig)
				since_fall <= 16'h0001;
			else if (since_fall != 16'hFFFF)
				since_fall <= since_fall + 16'h0001;
			pulsed_r <= busy_o && (pulsed_r || !pulse);
		end
	end

	// first and later pulse starts of a burst
	sequence first_fall;
		$fell(pulse) && !pulsed_r;
	endsequence
	sequence next_fall;
		$fell(pulse) && pulsed_r;
	endsequence

	chk_trig_min: assert property ($rose(trig) |-> tlow_cnt >= `PPT_TRIG_MIN_CYC)
		else $error("trigger pulse too short");
	chk_trig_rest: assert property (tlow_cnt <= TRIG_CYC + 1)
		else $error("trigger line not back at rest");
	chk_idle_high: assert property (!busy_o |-> pulse)
		else $error("pulse line low outside a burst");
	chk_fall_start: assert property ($rose(busy_o) |-> since_fall <= 16'h0008)
		else $error("burst accepted without a trigger falling edge");
	chk_start_delay: assert property (first_fall |-> since_fall >= START_CYC && since_fall <= START_CYC + 10)
		else $error("first pulse outside the start window");
	chk_low_phase: assert property ($rose(pulse) |-> low_cnt == half)
		else $error("pulse low phase wrong length");
	chk_high_phase: assert property (next_fall |-> high_cnt == half)
		else $error("pulse high phase wrong length");
	chk_len_hold: assert property (busy_o && $past(busy_o) |-> $stable(burst_len_o))
		else $error("burst length changed during a burst");
endmodule : ppt_assertions

// file: sim/pressure_pulse_train_output_test.sv
// self-checking bench joining the barometer end and the host counter end
`timescale 1ns/1ps
`include "ppt_defs.svh"
module pressure_pulse_train_output_test;
	import ppt_pkg::*;
	localparam int unsigned START_CYC = 20;
	localparam int unsigned SLOW_HALF = 10;
	localparam int unsigned FAST_HALF = 4;
	localparam int unsigned MS_CYC    = 100;
	logic        clk_i, resetn_i, pen, sw, fast, hres, err, busy, cyc, stb, we, ack;
	ppt_unit_t   unit;
	logic [23:0] press, offs, blen;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	int          bad_count, checks;

	ppt_if link_if ();
	ppt_device #(.START_CYC(START_CYC), .SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) i_ppt_device (
		.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'h1), .link(link_if), .pulse_enable_i(pen),
		.trigger_wait_enable_switch_i(sw), .unit_i(unit), .fast_rate_i(fast), .high_res_i(hres),
		.error_i(err), .pressure_i(press), .offset_i(offs), .busy_o(busy), .burst_len_o(blen));
	ppt_host #(.MS_CYC(MS_CYC)) i_ppt_host (
		.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'h1), .link(link_if), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	ppt_assertions #(.START_CYC(START_CYC), .SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) i_ppt_assertions (
		.clk_i(clk_i), .resetn_i(resetn_i), .trig(link_if.trig), .pulse(link_if.pulse), .busy_o(busy),
		.fast_rate_i(fast), .burst_len_o(blen));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	// one classic cycle; ack and read data taken at the same edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do @(posedge clk_i); while (ack !== 1'h1);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb

	task wait_done;
		do wb(1'h0, `PPT_REG_STATUS, 32'h0); while (q[`PPT_STAT_DONE] !== 1'h1);
	endtask : wait_done

	// one measurement: start, wait for gate end, read the count
	task run(input logic [23:0] exp);
		wb(1'h1, `PPT_REG_CTRL, 32'h1);
		wait_done();
		wb(1'h0, `PPT_REG_COUNT, 32'h0);
		chk("pulse count", {8'h00, exp}, q);
	endtask : run

	task setdev(input ppt_unit_t u, input logic f, h, e, p, s, input logic [23:0] pr, of);
		@(posedge clk_i);
		unit <= u;
		fast <= f;
		hres <= h;
		err <= e;
		pen <= p;
		sw <= s;
		press <= pr;
		offs <= of;
	endtask : setdev

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk("trig rest", 32'h1, link_if.trig);
		chk("pulse rest", 32'h1, link_if.pulse);
		wb(1'h0, `PPT_REG_GATE, 32'h0);
		chk("gate reset", `PPT_GATE_MS_RST, q[15:0]);
		wb(1'h0, 8'h10, 32'h0);
		chk("unmapped read", 32'h0, q);
		// 20 ms gate holds the longest burst used below
		wb(1'h1, `PPT_REG_GATE, 32'h14);
		wb(1'h0, `PPT_REG_GATE, 32'h0);
		chk("gate write", 32'h14, q[15:0]);
	endtask : t_reset

	// (12.34 - 10.00) hPa in tenths, truncated
	task t_slow_low;
		setdev(PPT_UNIT_HPA, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 24'h0004D2, 24'hFFFC18);
		run(24'h000017);
		chk("burst length", 32'h17, blen);
	endtask : t_slow_low

	// (2.00 - 0.50) mbar in hundredths at the fast rate
	task t_fast_high;
		setdev(PPT_UNIT_MBAR, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 24'h0000C8, 24'hFFFFCE);
		run(24'h000096);
		setdev(PPT_UNIT_MBAR, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 24'h000064, 24'hFFFF38);
		run(24'h000000);
	endtask : t_fast_high

	task t_units;
		for (int i = 0; i < 9; i++) begin
			setdev(ppt_unit_t'(i[3:0]), 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 24'h000032, 24'h000000);
			run((i == 0 || i == 3) ? 24'h000032 : 24'h000000);
		end
	endtask : t_units

	task t_refused;
		setdev(PPT_UNIT_HPA, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 24'h000032, 24'h000000);
		run(24'h000000);
		setdev(PPT_UNIT_HPA, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 24'h000032, 24'h000000);
		run(24'h000000);
		setdev(PPT_UNIT_HPA, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 24'h000032, 24'h000000);
		run(24'h000000);
		// error raised inside the start delay must cancel the burst
		setdev(PPT_UNIT_HPA, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 24'h000032, 24'h000000);
		wb(1'h1, `PPT_REG_CTRL, 32'h1);
		repeat (8) @(posedge clk_i);
		err <= 1'h1;
		wait_done();
		chk("abort idle", 32'h0, busy);
		wb(1'h0, `PPT_REG_COUNT, 32'h0);
		chk("aborted count", 32'h0, q);
	endtask : t_refused

	// short gate lets a second trigger land mid-burst; a restart would stretch busy
	task t_retrig;
		int c;
		wb(1'h1, `PPT_REG_GATE, 32'h1);
		setdev(PPT_UNIT_HPA, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 24'h0000C8, 24'h000000);
		wb(1'h1, `PPT_REG_CTRL, 32'h1);
		wb(1'h0, `PPT_REG_STATUS, 32'h0);
		chk("status trigger", 32'h1, q);
		repeat (60) @(posedge clk_i);
		wb(1'h0, `PPT_REG_STATUS, 32'h0);
		chk("status gate", 32'h5, q);
		wait_done();
		chk("status done", 32'h2, q);
		// a gate shorter than the burst loses the tail of it
		wb(1'h0, `PPT_REG_COUNT, 32'h0);
		chk("cut gate count", 32'h1, q != 32'h0 && q < 32'h14);
		wb(1'h1, `PPT_REG_CTRL, 32'h1);
		c = 0;
		while (busy !== 1'h0 && c < 2000) begin
			@(posedge clk_i);
			c++;
		end
		chk("burst not restarted", 32'h1, c <= 40 * SLOW_HALF + START_CYC + 10 - MS_CYC);
		chk("burst length kept", 32'h14, blen);
		wait_done();
		wb(1'h1, `PPT_REG_GATE, 32'h14);
		run(24'h000014);
	endtask : t_retrig

	task wrap_up;
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// clock, main sequence, watchdog
	// ----------------------------------------
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		{resetn_i, cyc, stb, we, pen, sw, fast, hres, err} = 9'h000;
		{adr, sel, wdat, press, offs} = 92'h0;
		unit = PPT_UNIT_HPA;
		bad_count = 0;
		checks = 0;
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_slow_low();
		t_fast_high();
		t_units();
		t_refused();
		t_retrig();
		wrap_up();
	end

	// whole run needs about 40k cycles
	initial begin
		repeat (100000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end
endmodule : pressure_pulse_train_output_test
